/* File: design/srx_edge_sync.sv */
// Two-stage synchroniser with change detect for one modem input
`timescale 1ns/1ps
`default_nettype none
module srx_edge_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Modem line
  input wire logic async_in,
  output logic change
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [2:0] primed;
  } srx_sync_state_t;

  srx_sync_state_t r;
  srx_sync_state_t n;

  always_comb begin
    n = r;
    n.s1 = async_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.primed = {r.primed[1:0], 1'b1};
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r <= '{1'b0, 1'b0, 1'b0, srx_pkg::PRIME_RESET};
    end else begin
      r <= n;
    end
  end

  // Quiet until the pipe is filled, so a line high at reset is no change
  assign change = r.primed[2] & (r.s2 ^ r.s3);

  sync_change_a: assert property (@(posedge mclk) disable iff (!nrst)
    $changed(async_in) && r.primed[2] |-> ##2 change)
    else $error("modem change not flagged two cycles later");
endmodule : srx_edge_sync
`default_nettype wire

/* File: design/srx_status_flags.sv */
// Receive and modem-change status bits 31:26 and 11:4 with interrupt
`timescale 1ns/1ps
`default_nettype none
module srx_status_flags (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Receive path state
  input wire logic [5:0] rx_fifo_count,
  input wire logic rx_fifo_full,
  input wire logic rx_data_avail,
  input wire logic rx_buffer_close,
  input wire logic [5:0] rx_close_status,
  // Modem lines
  input wire logic dcd_in,
  input wire logic ri_in,
  input wire logic dsr_in,
  input wire logic cts_in,
  // Descriptor write-back
  output logic desc_wr,
  output logic [5:0] desc_status,
  // Flags out
  output logic rx_ready_flag,
  output logic irq
);
  typedef struct packed {
    srx_pkg::srx_close_state_t close_st;
    logic [5:0] frozen;
    logic [31:0] irq_en;
    logic dma_mode;
    logic [31:0] rdata;
  } srx_top_state_t;

  srx_top_state_t r;
  srx_top_state_t n;

  logic [3:0] modem_lines;
  logic [3:0] modem_chg;
  logic [3:0] modem_flags;
  logic sts_wr;
  logic close_ack;
  logic rx_buffer_closed_flag;
  logic rx_half_full_flag;
  logic [31:0] status_word;

  assign modem_lines = {dcd_in, ri_in, dsr_in, cts_in};
  assign sts_wr = reg_wr && (reg_addr == srx_pkg::STATUS_OFS);
  assign close_ack = sts_wr && reg_wdata[srx_pkg::CLOSED_BIT];

  // Index 0 is clear-to-send at bit 4, up to carrier detect at bit 7
  srx_flag_if mf[4] ();
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_modem
      srx_edge_sync u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .async_in(modem_lines[g]),
        .change(modem_chg[g])
      );
      assign mf[g].set = modem_chg[g];
      assign mf[g].clr = sts_wr && reg_wdata[srx_pkg::CTS_BIT + g];
      assign modem_flags[g] = mf[g].flag;
      srx_sticky u_flag (
        .mclk(mclk),
        .nrst(nrst),
        .fl(mf[g])
      );
    end
  endgenerate

  assign rx_buffer_closed_flag = (r.close_st != srx_pkg::CLS_OPEN);
  assign rx_half_full_flag = (rx_fifo_count >= srx_pkg::HALF_LEVEL);
  assign rx_ready_flag = rx_data_avail && !rx_buffer_closed_flag;

  always_comb begin
    status_word = 32'h0000_0000;
    // Frozen capture while closed so software reads a stable snapshot
    status_word[srx_pkg::FRZ_LSB +: srx_pkg::FRZ_W] =
      rx_buffer_closed_flag ? r.frozen : rx_close_status;
    status_word[srx_pkg::READY_BIT] = rx_ready_flag;
    status_word[srx_pkg::HALF_BIT] = rx_half_full_flag;
    status_word[srx_pkg::CLOSED_BIT] = rx_buffer_closed_flag;
    status_word[srx_pkg::FULL_BIT] = rx_fifo_full;
    status_word[srx_pkg::CTS_BIT +: 4] = modem_flags;
  end

  always_comb begin
    n = r;
    n.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        srx_pkg::STATUS_OFS: n.rdata = status_word;
        srx_pkg::IRQ_EN_OFS: n.rdata = r.irq_en;
        srx_pkg::CTRL_OFS: n.rdata = {31'h0000_0000, r.dma_mode};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    if (reg_wr && reg_addr == srx_pkg::IRQ_EN_OFS) begin
      n.irq_en = reg_wdata & srx_pkg::IRQ_MASK;
    end
    if (reg_wr && reg_addr == srx_pkg::CTRL_OFS) begin
      n.dma_mode = reg_wdata[srx_pkg::DMA_BIT];
    end
    case (r.close_st)
      srx_pkg::CLS_OPEN: begin
        if (rx_buffer_close) begin
          n.frozen = rx_close_status;
          n.close_st = r.dma_mode ? srx_pkg::CLS_DMA : srx_pkg::CLS_HELD;
        end
      end
      srx_pkg::CLS_HELD: begin
        // A close landing with the acknowledge keeps the flag set
        if (close_ack && !rx_buffer_close) begin
          n.close_st = srx_pkg::CLS_OPEN;
        end
      end
      srx_pkg::CLS_DMA: begin
        // One cycle of write-back, then hardware acknowledges
        if (rx_buffer_close) begin
          n.frozen = rx_close_status;
          n.close_st = r.dma_mode ? srx_pkg::CLS_DMA : srx_pkg::CLS_HELD;
        end else begin
          n.close_st = srx_pkg::CLS_OPEN;
        end
      end
      default: n.close_st = srx_pkg::CLS_OPEN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r <= '{srx_pkg::CLS_OPEN, srx_pkg::FRZ_RESET, srx_pkg::IRQ_EN_RESET,
             srx_pkg::CTRL_DMA_RESET, 32'h0000_0000};
    end else begin
      r <= n;
    end
  end

  assign reg_rdata = r.rdata;
  assign desc_wr = (r.close_st == srx_pkg::CLS_DMA);
  assign desc_status = r.frozen;
  // Level interrupt; sticky flags clear through their own acknowledge, the others with their source
  assign irq = |(status_word & r.irq_en & srx_pkg::IRQ_MASK);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence close_in_dma_s;
    r.dma_mode && rx_buffer_close && r.close_st == srx_pkg::CLS_OPEN;
  endsequence
  sequence status_read_s;
    reg_rd && reg_addr == srx_pkg::STATUS_OFS;
  endsequence
  sequence writeback_s;
    desc_wr && desc_status == $past(rx_close_status);
  endsequence
  sequence auto_ack_s;
    !rx_buffer_closed_flag;
  endsequence

  half_flag_read_a: assert property (
    reg_rd && reg_addr == srx_pkg::STATUS_OFS |=>
      reg_rdata[srx_pkg::HALF_BIT] ==
      ($past(rx_fifo_count) >= srx_pkg::HALF_LEVEL))
    else $error("half-full bit wrong on read");
  full_flag_read_a: assert property (
    reg_rd && reg_addr == srx_pkg::STATUS_OFS |=>
      reg_rdata[srx_pkg::FULL_BIT] == $past(rx_fifo_full))
    else $error("full bit does not follow FIFO state");
  close_set_a: assert property (
    rx_buffer_close && !r.dma_mode |=> rx_buffer_closed_flag)
    else $error("buffer-closed not set on close");
  close_hold_a: assert property (
    r.close_st == srx_pkg::CLS_HELD && !close_ack |=> rx_buffer_closed_flag)
    else $error("buffer-closed dropped without acknowledge");
  close_ack_a: assert property (
    r.close_st == srx_pkg::CLS_HELD && close_ack && !rx_buffer_close
      |=> !rx_buffer_closed_flag)
    else $error("buffer-closed not cleared by write of one");
  close_wins_a: assert property (
    r.close_st == srx_pkg::CLS_HELD && close_ack && rx_buffer_close
      |=> rx_buffer_closed_flag)
    else $error("close beside acknowledge lost the flag");
  frozen_capture_a: assert property (
    rx_buffer_close && r.close_st == srx_pkg::CLS_OPEN
      |=> r.frozen == $past(rx_close_status))
    else $error("closing status not captured at close");
  closed_read_a: assert property (
    status_read_s ##0 rx_buffer_closed_flag |=>
      reg_rdata[srx_pkg::CLOSED_BIT] &&
      reg_rdata[srx_pkg::FRZ_LSB +: srx_pkg::FRZ_W] == $past(r.frozen))
    else $error("closed read lacks frozen status");
  live_status_a: assert property (
    status_read_s ##0 !rx_buffer_closed_flag |=>
      reg_rdata[srx_pkg::FRZ_LSB +: srx_pkg::FRZ_W] == $past(rx_close_status))
    else $error("open read does not show live status");
  ready_read_a: assert property (
    status_read_s |=> reg_rdata[srx_pkg::READY_BIT] == $past(rx_ready_flag))
    else $error("receive-ready bit wrong on read");
  modem_read_a: assert property (
    status_read_s |=>
      reg_rdata[srx_pkg::CTS_BIT +: 4] == $past(modem_flags))
    else $error("modem change bits wrong on read");
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not cleared after its cycle");
  dma_auto_ack_a: assert property (
    close_in_dma_s ##1 (desc_wr && !rx_buffer_close) |=> auto_ack_s)
    else $error("DMA close not acknowledged by hardware");
  dma_writeback_a: assert property (
    close_in_dma_s |=> writeback_s)
    else $error("descriptor write-back missing or wrong");
  dma_release_a: assert property (
    r.close_st == srx_pkg::CLS_DMA && !rx_buffer_close
      |=> !desc_wr && !rx_buffer_closed_flag)
    else $error("DMA write-back not released after one cycle");
  dma_ready_a: assert property (
    close_in_dma_s ##1 (desc_wr && !rx_buffer_close)
      |=> !rx_data_avail || rx_ready_flag)
    else $error("receive-ready not restored after DMA close");
  desc_quiet_a: assert property (
    rx_buffer_close && !r.dma_mode |=> !desc_wr)
    else $error("descriptor write-back outside DMA mode");
  frozen_hold_a: assert property (
    r.close_st == srx_pkg::CLS_HELD && $past(r.close_st == srx_pkg::CLS_HELD)
      |-> $stable(r.frozen))
    else $error("closing status changed while closed");
  ready_interlock_a: assert property (
    rx_buffer_closed_flag |-> !rx_ready_flag)
    else $error("receive-ready active while closed");
  ready_avail_a: assert property (
    rx_data_avail && !rx_buffer_closed_flag |-> rx_ready_flag)
    else $error("receive-ready missing with data");
  irq_gate_a: assert property (
    irq |-> (rx_ready_flag && r.irq_en[srx_pkg::READY_BIT]) ||
      (rx_half_full_flag && r.irq_en[srx_pkg::HALF_BIT]) ||
      (rx_buffer_closed_flag && r.irq_en[srx_pkg::CLOSED_BIT]) ||
      (rx_fifo_full && r.irq_en[srx_pkg::FULL_BIT]) ||
      |(modem_flags & r.irq_en[srx_pkg::CTS_BIT +: 4]))
    else $error("interrupt without enabled flag");
  half_irq_a: assert property (
    rx_half_full_flag && r.irq_en[srx_pkg::HALF_BIT] |-> irq)
    else $error("enabled half-full gives no interrupt");
  close_irq_a: assert property (
    rx_buffer_closed_flag && r.irq_en[srx_pkg::CLOSED_BIT] |-> irq)
    else $error("enabled buffer-closed gives no interrupt");
  modem_irq_a: assert property (
    |(modem_flags & r.irq_en[srx_pkg::CTS_BIT +: 4]) |-> irq)
    else $error("enabled modem change gives no interrupt");
  irq_quiet_a: assert property (
    r.irq_en == srx_pkg::IRQ_EN_RESET |-> !irq)
    else $error("interrupt with every enable clear");
  enable_write_a: assert property (
    reg_wr && reg_addr == srx_pkg::IRQ_EN_OFS |=>
      r.irq_en == ($past(reg_wdata) & srx_pkg::IRQ_MASK))
    else $error("enable register write not taken");
  mode_write_a: assert property (
    reg_wr && reg_addr == srx_pkg::CTRL_OFS |=>
      r.dma_mode == $past(reg_wdata[srx_pkg::DMA_BIT]))
    else $error("DMA mode write not taken");
  dcd_set_a: assert property (
    modem_chg[3] |=> modem_flags[3])
    else $error("carrier change flag not set");
  ri_set_a: assert property (
    modem_chg[2] |=> modem_flags[2])
    else $error("ring change flag not set");
  dsr_set_a: assert property (
    modem_chg[1] |=> modem_flags[1])
    else $error("set-ready change flag not set");
  cts_set_a: assert property (
    modem_chg[0] |=> modem_flags[0])
    else $error("clear-to-send change flag not set");
  modem_ack_a: assert property (
    sts_wr && modem_chg == 4'h0 |=> modem_flags ==
      ($past(modem_flags) & ~$past(reg_wdata[srx_pkg::CTS_BIT +: 4])))
    else $error("modem flags not acknowledged by ones only");
  modem_keep_a: assert property (
    !sts_wr && modem_chg == 4'h0 |=> $stable(modem_flags))
    else $error("modem flags changed without cause");
  reset_clear_a: assert property (disable iff (1'b0)
    !nrst |=> !rx_buffer_closed_flag && r.irq_en == srx_pkg::IRQ_EN_RESET)
    else $error("flags not cleared by reset");
endmodule : srx_status_flags
`default_nettype wire

/* File: design/srx_sticky.sv */
// Sticky flag: set wins over a same-cycle clear
`timescale 1ns/1ps
`default_nettype none
module srx_sticky (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Flag bundle
  srx_flag_if.keeper fl
);
  typedef struct packed {
    logic flag;
  } srx_sticky_state_t;

  srx_sticky_state_t r;
  srx_sticky_state_t n;

  always_comb begin
    n = r;
    n.flag = fl.set | (r.flag & ~fl.clr);
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r <= '{flag: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign fl.flag = r.flag;

  sticky_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    (fl.set || (r.flag && !fl.clr)) |=> r.flag)
    else $error("sticky flag lost while not acknowledged");
  sticky_ack_a: assert property (@(posedge mclk) disable iff (!nrst)
    fl.clr && !fl.set |=> !r.flag)
    else $error("sticky flag not cleared by acknowledge");
endmodule : srx_sticky
`default_nettype wire

/* File: shared/srx_flag_if.sv */
// Set, clear and flag bundle between a change source and a sticky flag
`timescale 1ns/1ps
`default_nettype none
interface srx_flag_if;
  logic set;
  logic clr;
  logic flag;
  modport keeper (input set, input clr, output flag);
  modport driver (output set, output clr, input flag);
endinterface : srx_flag_if
`default_nettype wire

/* File: shared/srx_pkg.sv */
// Constants and types for the receive and modem status flag block
package srx_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] IRQ_EN_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS = 8'h08;
  // Status word field positions
  localparam int FRZ_LSB = 26;
  localparam int FRZ_W = 6;
  localparam int READY_BIT = 11;
  localparam int HALF_BIT = 10;
  localparam int CLOSED_BIT = 9;
  localparam int FULL_BIT = 8;
  localparam int DCD_BIT = 7;
  localparam int RI_BIT = 6;
  localparam int DSR_BIT = 5;
  localparam int CTS_BIT = 4;
  // Control register field
  localparam int DMA_BIT = 0;
  // Receive FIFO level
  localparam int CNT_W = 6;
  localparam logic [5:0] HALF_LEVEL = 6'h10;
  // Bits able to interrupt
  localparam logic [31:0] IRQ_MASK = 32'h0000_0ff0;
  // Reset values
  localparam logic [31:0] IRQ_EN_RESET = 32'h0000_0000;
  localparam logic CTRL_DMA_RESET = 1'h0;
  localparam logic [5:0] FRZ_RESET = 6'h00;
  localparam logic [2:0] PRIME_RESET = 3'h0;
  // Buffer-closed sequencing
  typedef enum logic [2:0] {
    CLS_OPEN = 3'h1,
    CLS_HELD = 3'h2,
    CLS_DMA = 3'h4
  } srx_close_state_t;
endpackage : srx_pkg

/* File: test/srx_far_model.sv */
// Far-side model: receive path state and modem lines
`timescale 1ns/1ps
`default_nettype none
module srx_far_model (
  // Clock
  input wire logic mclk,
  // Receive path
  output logic [5:0] count,
  output logic full,
  output logic avail,
  output logic close,
  output logic [5:0] cstat,
  // Modem lines, bit 3 carrier down to bit 0 clear-to-send
  output logic [3:0] modem
);
  initial begin
    count = 6'h00;
    close = 1'b0;
    cstat = 6'h00;
    modem = 4'h0;
  end
  assign full = (count == 6'h20);
  assign avail = (count != 6'h00);
  task automatic fill(input logic [5:0] n, input logic [5:0] st);
    @(posedge mclk);
    count <= n;
    cstat <= st;
  endtask : fill
  task automatic toggle(input int i);
    @(posedge mclk);
    modem[i] <= ~modem[i];
  endtask : toggle
  // Close is a single-cycle event, status launched beside it
  task automatic close_pulse(input logic [5:0] st);
    @(posedge mclk);
    close <= 1'b1;
    cstat <= st;
    @(posedge mclk);
    close <= 1'b0;
  endtask : close_pulse
endmodule : srx_far_model
`default_nettype wire

/* File: test/tb_top.sv */
// Top-level testbench for the receive and modem status flag block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk;
  logic nrst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [5:0] count;
  logic [5:0] cstat;
  logic full;
  logic avail;
  logic close;
  logic [3:0] modem;
  logic desc_wr;
  logic [5:0] desc_status;
  logic rx_ready_flag;
  logic irq;
  int n_errors = 0;
  int cmp_count = 0;
  localparam logic [7:0] ST = srx_pkg::STATUS_OFS;
  localparam logic [7:0] EN = srx_pkg::IRQ_EN_OFS;
  localparam logic [7:0] CT = srx_pkg::CTRL_OFS;

  srx_far_model i_srx_far_model (.mclk(mclk), .count(count), .full(full),
    .avail(avail), .close(close), .cstat(cstat), .modem(modem));
  srx_status_flags i_srx_status_flags (.mclk(mclk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_fifo_count(count),
    .rx_fifo_full(full), .rx_data_avail(avail), .rx_buffer_close(close),
    .rx_close_status(cstat), .dcd_in(modem[3]), .ri_in(modem[2]),
    .dsr_in(modem[1]), .cts_in(modem[0]), .desc_wr(desc_wr),
    .desc_status(desc_status), .rx_ready_flag(rx_ready_flag), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  function automatic logic [31:0] b(input int n);
    return 32'h1 << n;
  endfunction : b

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask : rchk

  task automatic summarize;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic t_reset;
    rchk("status", ST, 32'h0);
    rchk("enable", EN, 32'h0);
    rchk("control", CT, 32'h0);
    chk("irq", irq, 32'h0);
  endtask : t_reset

  task automatic t_levels;
    i_srx_far_model.fill(6'h0f, 6'h00);
    rchk("below half", ST, b(11));
    i_srx_far_model.fill(6'h10, 6'h00);
    rchk("half", ST, b(11) | b(10));
    i_srx_far_model.fill(6'h20, 6'h00);
    rchk("full", ST, b(11) | b(10) | b(8));
    wr(ST, 32'hffff_ffff);
    rchk("read-only", ST, b(11) | b(10) | b(8));
    wr(EN, b(10));
    chk("half irq", irq, 32'h1);
    wr(EN, 32'h0);
    chk("half masked", irq, 32'h0);
    i_srx_far_model.fill(6'h1f, 6'h00);
    rchk("full gone", ST, b(11) | b(10));
    rchk("unmapped", 8'h0c, 32'h0);
    i_srx_far_model.fill(6'h00, 6'h00);
  endtask : t_levels

  task automatic t_modem;
    for (int i = 0; i < 4; i++) begin
      i_srx_far_model.toggle(i);
      repeat (5) @(posedge mclk);
      rchk("change set", ST, b(4 + i));
      wr(EN, b(4 + i));
      chk("change irq", irq, 32'h1);
      wr(ST, 32'h0);
      rchk("write zero", ST, b(4 + i));
      wr(ST, b(4 + i));
      rchk("ack", ST, 32'h0);
      chk("irq off", irq, 32'h0);
      wr(EN, 32'h0);
    end
  endtask : t_modem

  task automatic t_close;
    i_srx_far_model.fill(6'h04, 6'h00);
    i_srx_far_model.close_pulse(6'h2a);
    #1;
    chk("ready held", rx_ready_flag, 32'h0);
    i_srx_far_model.fill(6'h04, 6'h15);
    rchk("closed", ST, {6'h2a, 26'h0} | b(9));
    wr(EN, b(9));
    chk("close irq", irq, 32'h1);
    wr(ST, 32'h0);
    rchk("still closed", ST, {6'h2a, 26'h0} | b(9));
    wr(ST, b(9));
    rchk("acked", ST, {6'h15, 26'h0} | b(11));
    chk("irq off", irq, 32'h0);
    wr(EN, 32'h0);
  endtask : t_close

  task automatic t_dma;
    wr(CT, 32'h1);
    i_srx_far_model.close_pulse(6'h33);
    #1;
    chk("desc strobe", desc_wr, 32'h1);
    chk("desc status", desc_status, 32'h33);
    chk("ready held", rx_ready_flag, 32'h0);
    @(posedge mclk);
    #1;
    chk("desc end", desc_wr, 32'h0);
    chk("ready back", rx_ready_flag, 32'h1);
    rchk("auto ack", ST, {6'h33, 26'h0} | b(11));
    wr(CT, 32'h0);
  endtask : t_dma

  // Reset in mid-run with flags set; carrier, ring and set-ready lines stay high across it, clear-to-send low
  task automatic t_mid_reset;
    wr(EN, b(9));
    i_srx_far_model.close_pulse(6'h0c);
    i_srx_far_model.toggle(0);
    repeat (5) @(posedge mclk);
    rchk("pre reset", ST, {6'h0c, 26'h0} | b(9) | b(4));
    chk("pre irq", irq, 32'h1);
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    rchk("reset status", ST, {6'h0c, 26'h0} | b(11));
    rchk("reset enable", EN, 32'h0);
    chk("reset irq", irq, 32'h0);
  endtask : t_mid_reset

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    summarize();
  end

  initial begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset();
    t_levels();
    t_modem();
    t_close();
    t_dma();
    t_mid_reset();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
